// ---- bench/pdcg_properties.sv ----
`timescale 1ns/1ns
module pdcg_properties (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq_wake,
    input wire logic        fast_xtal_run,
    input wire logic        fast_rc_osc_run,
    input wire logic        sys_clk_run,
    input wire logic        pll_run,
    input wire logic        core_clk_run,
    input wire logic        rtc_wdt_clk_run,
    input wire logic        ext_bus_clk_run,
    input wire logic        flash_prog_clk_run,
    input wire logic        periph_dma_clk_run,
    input wire logic        in_power_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // wake delay length counter
    // ----------------------------------------
    logic [13:0] dly_cnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_cnt <= 14'h0;
        end else if (sys_clk_run || in_power_down) begin
            dly_cnt <= 14'h0;
        end else if (dly_cnt != 14'h3fff) begin
            dly_cnt <= dly_cnt + 14'h1;
        end
    end

    chk_pd_clocks_off:
    assert property (in_power_down |-> !sys_clk_run && !pll_run && !core_clk_run && !fast_xtal_run
        && !fast_rc_osc_run) else $error("fast clock running in power-down");
    chk_rtc_wdt_on:
    assert property (in_power_down |-> rtc_wdt_clk_run) else $error("rtc/wdt clock off in power-down");
    chk_wake_exit:
    assert property (in_power_down && irq_wake |=> !in_power_down) else $error("no wake on interrupt");
    chk_wake_hold_off:
    assert property ($fell(in_power_down) && !sys_clk_run |-> !sys_clk_run [*8])
        else $error("system clock released early");
    chk_delay_bound:
    assert property (dly_cnt <= 14'h1000) else $error("wake delay too long");
    chk_bus_gate:
    assert property (ext_bus_clk_run || flash_prog_clk_run || periph_dma_clk_run |-> sys_clk_run)
        else $error("engine clock without system clock");
    chk_core_run_only:
    assert property (core_clk_run |-> sys_clk_run && !in_power_down) else $error("core clock in sleep");
    chk_ready_pulse:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
    chk_err_read_zero:
    assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
endmodule

bind power_down_clock_gating_control pdcg_properties i_pdcg_properties (.clk, .rst_b, .psel, .penable,
    .prdata, .pready, .pslverr, .irq_wake, .fast_xtal_run, .fast_rc_osc_run, .sys_clk_run, .pll_run,
    .core_clk_run, .rtc_wdt_clk_run, .ext_bus_clk_run, .flash_prog_clk_run, .periph_dma_clk_run,
    .in_power_down);

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    $display("ERROR %s expected %h seen %h", nm, ex, got); fails++; end end
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr;
    logic        wait_for_interrupt = 1'b0, irq_wake = 1'b0, sys_clk_from_xtal = 1'b0;
    logic [2:0]  user_config_word = 3'h0;
    logic        fast_xtal_run, slow_xtal_run, fast_rc_osc_run, slow_rc_osc_run;
    logic        sys_clk_run, pll_run, core_clk_run, periph_clk_run, rtc_wdt_clk_run;
    logic        ext_bus_clk_run, flash_prog_clk_run, periph_dma_clk_run, wake_irq, in_power_down;
    int          fails = 0, check_count = 0, n;

    always #4 clk = ~clk;

    power_down_clock_gating_control i_power_down_clock_gating_control (.clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .user_config_word,
        .wait_for_interrupt, .irq_wake, .sys_clk_from_xtal, .fast_xtal_run, .slow_xtal_run,
        .fast_rc_osc_run, .slow_rc_osc_run, .sys_clk_run, .pll_run, .core_clk_run, .periph_clk_run,
        .rtc_wdt_clk_run, .ext_bus_clk_run, .flash_prog_clk_run, .periph_dma_clk_run, .wake_irq,
        .in_power_down);

    // ----------------------------------------
    // bus and timing tasks
    // ----------------------------------------
    task end_sim;
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 20) begin fails++; end_sim(); end
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task wake(output int c);
        @(posedge clk) irq_wake <= 1'b1;
        @(posedge clk) irq_wake <= 1'b0;
        #1;
        c = 0;
        while (sys_clk_run !== 1'b1 && c < 5000) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c >= 5000) begin fails++; end_sim(); end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, 12'h000, 0); `CHK("pwr_ctrl reset", 32'h0000_001d, rdat)
        apb(0, 12'h004, 0); `CHK("bus_clk reset", 32'h0000_000c, rdat)
        tick(1); `CHK("engine runs reset", 3'b110, {ext_bus_clk_run, flash_prog_clk_run, periph_dma_clk_run})
        apb(0, 12'h008, 0); `CHK("unmapped err", 2'b10, {rerr, rdat[0]})
        apb(1, 12'h000, 32'h0); apb(0, 12'h000, 0); `CHK("locked write", 32'h0000_001d, rdat)
        apb(1, 12'h00c, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h000, 32'h10 | (32'h1 << i)); tick(2);
            `CHK("osc runs", 4'h1 << i, {slow_rc_osc_run, fast_rc_osc_run, slow_xtal_run, fast_xtal_run})
        end
        apb(1, 12'h004, 32'hffff_ffff); apb(0, 12'h004, 0); `CHK("bus_clk mask", 32'h0000_000e, rdat)
        tick(1); `CHK("engines on", 3'b111, {ext_bus_clk_run, flash_prog_clk_run, periph_dma_clk_run})
        apb(1, 12'h004, 32'h0); tick(2);
        `CHK("engines off", 3'b000, {ext_bus_clk_run, flash_prog_clk_run, periph_dma_clk_run})
        apb(1, 12'h004, 32'he);
        @(posedge clk) wait_for_interrupt <= 1'b1;
        tick(2); `CHK("idle clocks", 3'b010, {core_clk_run, sys_clk_run, in_power_down})
        @(posedge clk) wait_for_interrupt <= 1'b0;
        tick(2); `CHK("normal clocks", 3'b110, {core_clk_run, sys_clk_run, in_power_down})
        apb(1, 12'h000, 32'h0af); tick(2);
        `CHK("pd state", 4'b1111, {in_power_down, slow_xtal_run, slow_rc_osc_run, rtc_wdt_clk_run})
        `CHK("pd fast off", 5'h0, {sys_clk_run, pll_run, fast_xtal_run, ext_bus_clk_run, periph_clk_run})
        wake(n); `CHK("no delay", 0, n)
        `CHK("woken", 1'b0, in_power_down)
        apb(0, 12'h000, 0); `CHK("flag set req clear", 32'h0000_006f, rdat)
        tick(1); `CHK("wake irq", 1'b1, wake_irq)
        apb(1, 12'h000, 32'h06f); apb(0, 12'h000, 0); `CHK("flag w1c", 32'h0000_002f, rdat)
        tick(1); `CHK("wake irq off", 1'b0, wake_irq)
        apb(1, 12'h000, 32'h19f); tick(4); `CHK("wait core", 1'b0, in_power_down)
        @(posedge clk) wait_for_interrupt <= 1'b1;
        tick(2); `CHK("deep sleep", 1'b1, in_power_down)
        @(posedge clk) wait_for_interrupt <= 1'b0;
        wake(n); `CHK("rc delay", 256, n)
        @(posedge clk);
        sys_clk_from_xtal <= 1'b1;
        apb(1, 12'h000, 32'h09f); tick(2); `CHK("pd again", 1'b1, in_power_down)
        wake(n); `CHK("xtal delay", 4096, n)
        @(posedge clk);
        user_config_word <= 3'h7;
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, 12'h000, 0); `CHK("strap no xtal", 32'h0000_001c, rdat)
        apb(0, 12'h004, 0); `CHK("bus_clk re-reset", 32'h0000_000c, rdat)
        end_sim();
    end
endmodule

// ---- hdl/clk_pwr_pkg.sv ----
package clk_pwr_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [11:0] PWR_CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] BUS_CLK_OFFSET    = 12'h004;
    localparam logic [11:0] UNLOCK_OFFSET     = 12'h00c;

    // ----------------------------------------
    // power control field positions
    // ----------------------------------------
    localparam int FAST_XTAL_BIT      = 0;
    localparam int SLOW_XTAL_BIT      = 1;
    localparam int FAST_RC_BIT        = 2;
    localparam int SLOW_RC_BIT        = 3;
    localparam int WAKE_DELAY_BIT     = 4;
    localparam int WAKE_IRQ_EN_BIT    = 5;
    localparam int WAKE_FLAG_BIT      = 6;
    localparam int SLEEP_REQ_BIT      = 7;
    localparam int WAIT_CORE_BIT      = 8;

    // ----------------------------------------
    // bus engine clock field positions
    // ----------------------------------------
    localparam int PERIPH_DMA_BIT     = 1;
    localparam int FLASH_PROG_BIT     = 2;
    localparam int EXT_BUS_BIT        = 3;
    localparam logic [31:0] BUS_CLK_RESET     = 32'h0000_000d;
    localparam logic [31:0] BUS_CLK_READ_MASK = 32'h0000_000e;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic SLOW_RC_RESET    = 1'h1;
    localparam logic FAST_RC_RESET    = 1'h1;
    localparam logic SLOW_XTAL_RESET  = 1'h0;
    localparam logic WAKE_DELAY_RESET = 1'h1;
    localparam logic UNLOCK_RESET     = 1'h0;

    // ----------------------------------------
    // clock source code selecting the fast crystal
    // ----------------------------------------
    localparam logic [2:0] CFG_SRC_FAST_XTAL = 3'h0;

    // ----------------------------------------
    // wake-up delay counts, in clock cycles
    // ----------------------------------------
    localparam logic [12:0] DELAY_XTAL_CYCLES = 13'h1000;
    localparam logic [12:0] DELAY_RC_CYCLES   = 13'h0100;

    // ----------------------------------------
    // power mode states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_DELAY = 4'b1000
    } pwr_state_e;

endpackage

// ---- hdl/power_down_clock_gating_control.sv ----
`timescale 1ns/1ns
// Overview of operation
// - with wake delay enabled, hold system clock off a fixed count after wake.
// - running from fast crystal at wake, delay counts 4096 cycles.
// - running from internal fast oscillator at wake, delay counts 256 cycles.
// - control bit 3 turns the slow internal oscillator on or off.
// - control bit 2 turns the fast internal oscillator on or off.
// - control bit 1 turns the slow crystal on or off.
// - control bit 0 turns the fast crystal on or off.
// - fast crystal enable resets from config field, set when it selects crystal.
// - delay enable and oscillator enables accept writes only while unlocked.
// - no sleep request and no core wait: clocks follow enable registers only.
// - core wait without sleep request enters idle, stopping only core clock.
// - power-down stops most clocks; slow sources, timer and watchdog clocks run.
// - sleep request plus wait-for-core enters power-down only on core wait.
// - an enabled interrupt source asserting leaves power-down.
// - bus clock bit 3 gates the external bus engine clock.
// - bus clock bit 2 gates the flash programming engine clock.
// - bus clock bit 1 gates the peripheral DMA engine clock.
// - bus clock register resets to 0xc; bits 31..4 and 0 read zero.
// - sleep request clears itself on wake; software sets it again.
// - in power-down the PLL and system clock are off regardless of source.
// - wake sets a flag only when enabled, write one clears it, interrupt when flag and enable.
module power_down_clock_gating_control #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [2:0]        user_config_word,
    input  wire logic              wait_for_interrupt,
    input  wire logic              irq_wake,
    input  wire logic              sys_clk_from_xtal,
    output logic                   fast_xtal_run,
    output logic                   slow_xtal_run,
    output logic                   fast_rc_osc_run,
    output logic                   slow_rc_osc_run,
    output logic                   sys_clk_run,
    output logic                   pll_run,
    output logic                   core_clk_run,
    output logic                   periph_clk_run,
    output logic                   rtc_wdt_clk_run,
    output logic                   ext_bus_clk_run,
    output logic                   flash_prog_clk_run,
    output logic                   periph_dma_clk_run,
    output logic                   wake_irq,
    output logic                   in_power_down
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    clk_pwr_pkg::pwr_state_e state;
    clk_pwr_pkg::pwr_state_e next_state;

    logic        fast_xtal_on;
    logic        slow_xtal_on;
    logic        fast_rc_osc_on;
    logic        slow_rc_osc_on;
    logic        wake_delay_enable;
    logic        wake_irq_enable;
    logic        wake_flag;
    logic        sleep_request;
    logic        sleep_wait_for_core;
    logic        write_unlocked;
    logic [3:1]  bus_clk;
    logic        strap_loaded;
    logic [12:0] delay_count;
    logic [31:0] next_prdata;
    logic        addr_hit;
    logic        wr_done;
    logic        wr_pwr;
    logic        wr_bus;
    logic        wr_unlock;
    logic        wake_event;
    logic        enter_sleep;
    logic        clocks_up;
    logic [11:0] addr;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign addr      = 12'(paddr);
    assign addr_hit  = (addr == clk_pwr_pkg::PWR_CTRL_OFFSET)
                     | (addr == clk_pwr_pkg::BUS_CLK_OFFSET)
                     | (addr == clk_pwr_pkg::UNLOCK_OFFSET);
    assign wr_done   = psel & penable & pready & pwrite & addr_hit;
    assign wr_pwr    = wr_done & (addr == clk_pwr_pkg::PWR_CTRL_OFFSET);
    assign wr_bus    = wr_done & (addr == clk_pwr_pkg::BUS_CLK_OFFSET);
    assign wr_unlock = wr_done & (addr == clk_pwr_pkg::UNLOCK_OFFSET);

    // ----------------------------------------
    // apb answer, one cycle after setup
    // ----------------------------------------
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (addr)
            clk_pwr_pkg::PWR_CTRL_OFFSET: begin
                next_prdata[clk_pwr_pkg::FAST_XTAL_BIT]   = fast_xtal_on;
                next_prdata[clk_pwr_pkg::SLOW_XTAL_BIT]   = slow_xtal_on;
                next_prdata[clk_pwr_pkg::FAST_RC_BIT]     = fast_rc_osc_on;
                next_prdata[clk_pwr_pkg::SLOW_RC_BIT]     = slow_rc_osc_on;
                next_prdata[clk_pwr_pkg::WAKE_DELAY_BIT]  = wake_delay_enable;
                next_prdata[clk_pwr_pkg::WAKE_IRQ_EN_BIT] = wake_irq_enable;
                next_prdata[clk_pwr_pkg::WAKE_FLAG_BIT]   = wake_flag;
                next_prdata[clk_pwr_pkg::SLEEP_REQ_BIT]   = sleep_request;
                next_prdata[clk_pwr_pkg::WAIT_CORE_BIT]   = sleep_wait_for_core;
            end
            clk_pwr_pkg::BUS_CLK_OFFSET: begin
                next_prdata[3:1] = bus_clk;
            end
            clk_pwr_pkg::UNLOCK_OFFSET: begin
                next_prdata[0] = write_unlocked;
            end
            default: begin
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pready  <= 1'b1;
            pslverr <= !addr_hit;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // write protection
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_unlocked <= clk_pwr_pkg::UNLOCK_RESET;
        end else if (wr_unlock) begin
            write_unlocked <= pwdata[0];
        end
    end

    // ----------------------------------------
    // oscillator and crystal enables
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_xtal_on      <= clk_pwr_pkg::SLOW_XTAL_RESET;
            fast_rc_osc_on    <= clk_pwr_pkg::FAST_RC_RESET;
            slow_rc_osc_on    <= clk_pwr_pkg::SLOW_RC_RESET;
            wake_delay_enable <= clk_pwr_pkg::WAKE_DELAY_RESET;
            wake_irq_enable   <= 1'b0;
        end else if (wr_pwr && write_unlocked) begin
            slow_rc_osc_on    <= pwdata[clk_pwr_pkg::SLOW_RC_BIT];
            fast_rc_osc_on    <= pwdata[clk_pwr_pkg::FAST_RC_BIT];
            slow_xtal_on      <= pwdata[clk_pwr_pkg::SLOW_XTAL_BIT];
            wake_delay_enable <= pwdata[clk_pwr_pkg::WAKE_DELAY_BIT];
            wake_irq_enable   <= pwdata[clk_pwr_pkg::WAKE_IRQ_EN_BIT];
        end
    end

    // fast crystal enable, default caught after reset release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_loaded <= 1'b0;
            fast_xtal_on <= 1'b0;
        end else if (!strap_loaded) begin
            strap_loaded <= 1'b1;
            fast_xtal_on <= (user_config_word == clk_pwr_pkg::CFG_SRC_FAST_XTAL);
        end else if (wr_pwr && write_unlocked) begin
            fast_xtal_on <= pwdata[clk_pwr_pkg::FAST_XTAL_BIT];
        end
    end

    // ----------------------------------------
    // power-down entry bits
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_wait_for_core <= 1'b0;
        end else if (wr_pwr && write_unlocked) begin
            sleep_wait_for_core <= pwdata[clk_pwr_pkg::WAIT_CORE_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_request <= 1'b0;
        end else if (wake_event) begin
            sleep_request <= 1'b0;
        end else if (wr_pwr && write_unlocked) begin
            sleep_request <= pwdata[clk_pwr_pkg::SLEEP_REQ_BIT];
        end
    end

    // ----------------------------------------
    // wake flag and interrupt
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_flag <= 1'b0;
        end else if (wake_event && wake_irq_enable) begin
            wake_flag <= 1'b1;
        end else if (wr_pwr && pwdata[clk_pwr_pkg::WAKE_FLAG_BIT]) begin
            wake_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= wake_flag & wake_irq_enable;
        end
    end

    // ----------------------------------------
    // bus engine clock enables
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_clk <= clk_pwr_pkg::BUS_CLK_RESET[3:1];
        end else if (wr_bus) begin
            bus_clk <= pwdata[3:1];
        end
    end

    // ----------------------------------------
    // power mode sequencing
    // ----------------------------------------
    // wait-for-core needs core wait; else immediate
    assign enter_sleep = sleep_request & (!sleep_wait_for_core | wait_for_interrupt);
    assign wake_event  = (state == clk_pwr_pkg::ST_SLEEP) & irq_wake;

    always_comb begin
        next_state = state;
        case (state)
            clk_pwr_pkg::ST_RUN: begin
                if (enter_sleep) begin
                    next_state = clk_pwr_pkg::ST_SLEEP;
                end else if (wait_for_interrupt) begin
                    next_state = clk_pwr_pkg::ST_IDLE;
                end
            end
            clk_pwr_pkg::ST_IDLE: begin
                if (enter_sleep) begin
                    next_state = clk_pwr_pkg::ST_SLEEP;
                end else if (!wait_for_interrupt) begin
                    next_state = clk_pwr_pkg::ST_RUN;
                end
            end
            clk_pwr_pkg::ST_SLEEP: begin
                if (irq_wake) begin
                    if (wake_delay_enable) begin
                        next_state = clk_pwr_pkg::ST_DELAY;
                    end else begin
                        next_state = clk_pwr_pkg::ST_RUN;
                    end
                end
            end
            clk_pwr_pkg::ST_DELAY: begin
                if (delay_count == 13'h0001) begin
                    next_state = clk_pwr_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = clk_pwr_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= clk_pwr_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // wake-up delay counter
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_count <= 13'h0000;
        end else if (wake_event && wake_delay_enable) begin
            if (sys_clk_from_xtal) begin
                delay_count <= clk_pwr_pkg::DELAY_XTAL_CYCLES;
            end else begin
                delay_count <= clk_pwr_pkg::DELAY_RC_CYCLES;
            end
        end else if (state == clk_pwr_pkg::ST_DELAY) begin
            delay_count <= delay_count - 13'h0001;
        end
    end

    // ----------------------------------------
    // clock gating outputs
    // ----------------------------------------
    // system clock and pll off in sleep and delay
    assign clocks_up = (next_state == clk_pwr_pkg::ST_RUN)
                     | (next_state == clk_pwr_pkg::ST_IDLE);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_xtal_run      <= 1'b0;
            slow_xtal_run      <= 1'b0;
            fast_rc_osc_run    <= 1'b0;
            slow_rc_osc_run    <= 1'b0;
            sys_clk_run        <= 1'b0;
            pll_run            <= 1'b0;
            core_clk_run       <= 1'b0;
            periph_clk_run     <= 1'b0;
            rtc_wdt_clk_run    <= 1'b0;
            ext_bus_clk_run    <= 1'b0;
            flash_prog_clk_run <= 1'b0;
            periph_dma_clk_run <= 1'b0;
            in_power_down      <= 1'b0;
        end else begin
            // fast sources stop in sleep, slow ones run
            fast_xtal_run      <= fast_xtal_on & (next_state != clk_pwr_pkg::ST_SLEEP);
            fast_rc_osc_run    <= fast_rc_osc_on & (next_state != clk_pwr_pkg::ST_SLEEP);
            slow_xtal_run      <= slow_xtal_on;
            slow_rc_osc_run    <= slow_rc_osc_on;
            rtc_wdt_clk_run    <= 1'b1;
            sys_clk_run        <= clocks_up;
            pll_run            <= clocks_up;
            periph_clk_run     <= clocks_up;
            // core clock runs only in run state
            core_clk_run       <= next_state == clk_pwr_pkg::ST_RUN;
            ext_bus_clk_run    <= bus_clk[clk_pwr_pkg::EXT_BUS_BIT] & clocks_up;
            flash_prog_clk_run <= bus_clk[clk_pwr_pkg::FLASH_PROG_BIT] & clocks_up;
            periph_dma_clk_run <= bus_clk[clk_pwr_pkg::PERIPH_DMA_BIT] & clocks_up;
            in_power_down      <= next_state == clk_pwr_pkg::ST_SLEEP;
        end
    end

endmodule
